// ### servo_stage_pkg.sv
// Shared constants and carrier types for the servo stage logic
package servo_stage_pkg;

    // ------------------------------------------------------------------
    // Converter and level widths
    // ------------------------------------------------------------------
    localparam int CODE_W      = 8;
    localparam int LEVEL_W     = 16;
    localparam int CMD_W       = LEVEL_W + 1;
    // Divide by 256: the converter scales reference by code/256
    localparam int SCALE_SHIFT = 8;
    localparam int PROD_W      = LEVEL_W + CODE_W;

    // Full-scale reference level, arbitrary fixed-point unit
    localparam logic [LEVEL_W-1:0] REF_LEVEL   = 16'hffff;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 16'h0000;
    localparam logic [CMD_W-1:0]   CMD_RESET   = 17'h00000;

    // ------------------------------------------------------------------
    // Start-up settling of the pin synchronisers
    // ------------------------------------------------------------------
    localparam int         PRIME_W    = 2;
    localparam logic [1:0] PRIME_ZERO = 2'h0;
    localparam logic [1:0] PRIME_ONE  = 2'h1;
    localparam logic [1:0] PRIME_DONE = 2'h3;

    // ------------------------------------------------------------------
    // Quadrature phase codes {pos_a, pos_b}
    // ------------------------------------------------------------------
    localparam logic [1:0] PH_0 = 2'h0;
    localparam logic [1:0] PH_1 = 2'h1;
    localparam logic [1:0] PH_2 = 2'h3;
    localparam logic [1:0] PH_3 = 2'h2;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic drive_forward_select;
        logic drive_reverse_select;
        logic hold_select;
        logic drive_disable;
    } servo_select_type;

    typedef struct packed {
        logic carriage;
        logic wheel;
        logic hammer;
    } sample_steer_type;

    typedef struct packed {
        logic pos_a;
        logic pos_b;
    } quad_type;

    localparam int SYNC_W = CODE_W + 3 + 4 + 4 + 2 + 2 + 3;

endpackage : servo_stage_pkg

// ### servo_stage.sv
// Digital side of the carriage / printwheel / hammer servo stage
// Behaviour
// - Converter level equals reference times code/256
// - Channel holds its value until next strobe
// - Position signals returned and decoded into steps
// - No absolute carriage position kept here
`timescale 1ns/1ps

module servo_stage
    import servo_stage_pkg::*;
(
    // Clock and reset
    input  wire logic                             i_mclk,
    input  wire logic                             i_srst,
    // Converter input and sample steering from the controller
    input  wire logic [servo_stage_pkg::CODE_W-1:0] i_dac_code,
    input  wire servo_stage_pkg::sample_steer_type  i_steer,
    // Direction, hold and disable selects per servo
    input  wire servo_stage_pkg::servo_select_type  i_car_sel,
    input  wire servo_stage_pkg::servo_select_type  i_wheel_sel,
    // Position comparator signals from the transducer path
    input  wire servo_stage_pkg::quad_type          i_car_quad,
    input  wire servo_stage_pkg::quad_type          i_wheel_quad,
    // Flag clears from the controller
    input  wire logic                             i_wheel_step_up_clear,
    input  wire logic                             i_wheel_step_down_clear,
    input  wire logic                             i_car_moved_clear,
    // Converter and held channel levels
    output logic [servo_stage_pkg::LEVEL_W-1:0]   o_dac_level,
    output logic [servo_stage_pkg::LEVEL_W-1:0]   o_car_held,
    output logic [servo_stage_pkg::LEVEL_W-1:0]   o_wheel_held,
    output logic [servo_stage_pkg::LEVEL_W-1:0]   o_hammer_energy,
    // Signed velocity commands at the summing points
    output logic [servo_stage_pkg::CMD_W-1:0]     o_car_command,
    output logic [servo_stage_pkg::CMD_W-1:0]     o_wheel_command,
    // Detent gating and power stage enables
    output logic                                  o_car_detent_gate,
    output logic                                  o_wheel_detent_gate,
    output logic                                  o_car_power_enable,
    output logic                                  o_wheel_power_enable,
    output logic [1:0]                            o_select_fault,
    // Position feedback back to the interface logic
    output servo_stage_pkg::quad_type             o_car_pos,
    output servo_stage_pkg::quad_type             o_wheel_pos,
    output logic                                  o_wheel_step_up_flag,
    output logic                                  o_wheel_step_down_flag,
    output logic                                  o_car_moved_flag
);
    import servo_stage_pkg::*;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [LEVEL_W-1:0] dac_level(
        input logic [CODE_W-1:0] code
    );
        logic [PROD_W-1:0] prod;
        prod = PROD_W'(REF_LEVEL) * PROD_W'(code);
        return prod[SCALE_SHIFT +: LEVEL_W];
    endfunction : dac_level

    // Returns {up, down}; a skipped phase counts as neither
    function automatic logic [1:0] quad_step(
        input logic [1:0] prev,
        input logic [1:0] cur
    );
        logic up;
        logic down;
        up   = (prev == PH_0 && cur == PH_1) || (prev == PH_1 && cur == PH_2)
            || (prev == PH_2 && cur == PH_3) || (prev == PH_3 && cur == PH_0);
        down = (prev == PH_1 && cur == PH_0) || (prev == PH_2 && cur == PH_1)
            || (prev == PH_3 && cur == PH_2) || (prev == PH_0 && cur == PH_3);
        return {up, down};
    endfunction : quad_step

    function automatic logic sel_fault(input servo_select_type s);
        return (s.drive_forward_select && s.drive_reverse_select)
            || ((s.drive_forward_select || s.drive_reverse_select)
                && s.hold_select);
    endfunction : sel_fault

    // Conflicting selects give no command at all rather than a guess
    function automatic logic [CMD_W-1:0] drive_command(
        input servo_select_type s,
        input logic [LEVEL_W-1:0] held
    );
        logic [CMD_W-1:0] mag;
        mag = {1'b0, held};
        if (sel_fault(s)) begin
            return CMD_RESET;
        end
        if (s.drive_forward_select) begin
            return mag;
        end
        if (s.drive_reverse_select) begin
            return CMD_W'(-mag);
        end
        return CMD_RESET;
    endfunction : drive_command

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [SYNC_W-1:0]  sync1;
    logic [SYNC_W-1:0]  sync2;
    logic [PRIME_W-1:0] prime;
    logic [PRIME_W-1:0] next_prime;
    quad_type           car_prev;
    quad_type           wheel_prev;

    logic [LEVEL_W-1:0] next_dac_level;
    logic [LEVEL_W-1:0] next_car_held;
    logic [LEVEL_W-1:0] next_wheel_held;
    logic [LEVEL_W-1:0] next_hammer_energy;
    logic [CMD_W-1:0]   next_car_command;
    logic [CMD_W-1:0]   next_wheel_command;
    logic               next_car_detent;
    logic               next_wheel_detent;
    logic               next_car_power;
    logic               next_wheel_power;
    logic [1:0]         next_fault;
    logic               next_step_up;
    logic               next_step_down;
    logic               next_car_moved;

    // Synchronised view of the pins
    logic [CODE_W-1:0]  s_code;
    sample_steer_type   s_steer;
    servo_select_type   s_car_sel;
    servo_select_type   s_wheel_sel;
    quad_type           s_car_quad;
    quad_type           s_wheel_quad;
    logic               s_clr_up;
    logic               s_clr_down;
    logic               s_clr_moved;
    logic [LEVEL_W-1:0] conv;
    logic [1:0]         wheel_step;
    logic [1:0]         car_step;
    logic               primed;

    assign {s_code, s_steer, s_car_sel, s_wheel_sel, s_car_quad,
            s_wheel_quad, s_clr_up, s_clr_down, s_clr_moved} = sync2;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        // Comparator edges seen before the synchronisers fill are noise
        primed     = (prime == PRIME_DONE);
        next_prime = primed ? prime : PRIME_W'(prime + PRIME_ONE);
        conv       = dac_level(s_code);
        wheel_step = primed ? quad_step(wheel_prev, s_wheel_quad) : 2'h0;
        car_step   = primed ? quad_step(car_prev, s_car_quad) : 2'h0;

        next_dac_level     = conv;
        // Hold element tracks only while its strobe is high
        next_car_held      = s_steer.carriage ? conv : o_car_held;
        next_wheel_held    = s_steer.wheel ? conv : o_wheel_held;
        next_hammer_energy = s_steer.hammer ? conv : o_hammer_energy;

        next_car_command   = drive_command(s_car_sel, o_car_held);
        next_wheel_command = drive_command(s_wheel_sel, o_wheel_held);
        next_car_detent    = s_car_sel.hold_select
                             && !sel_fault(s_car_sel);
        next_wheel_detent  = s_wheel_sel.hold_select
                             && !sel_fault(s_wheel_sel);
        next_car_power     = !s_car_sel.drive_disable;
        next_wheel_power   = !s_wheel_sel.drive_disable;
        next_fault         = {sel_fault(s_car_sel),
                              sel_fault(s_wheel_sel)};

        // Set beats clear so a step in the clearing cycle is kept
        next_step_up   = wheel_step[1]
                         || (o_wheel_step_up_flag && !s_clr_up);
        next_step_down = wheel_step[0]
                         || (o_wheel_step_down_flag && !s_clr_down);
        // Carriage motion only raises a flag; no count is kept
        next_car_moved = (car_step != 2'h0)
                         || (o_car_moved_flag && !s_clr_moved);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sync1                  <= '0;
            sync2                  <= '0;
            prime                  <= PRIME_ZERO;
            car_prev               <= '0;
            wheel_prev             <= '0;
            o_dac_level            <= LEVEL_RESET;
            o_car_held             <= LEVEL_RESET;
            o_wheel_held           <= LEVEL_RESET;
            o_hammer_energy        <= LEVEL_RESET;
            o_car_command          <= CMD_RESET;
            o_wheel_command        <= CMD_RESET;
            o_car_detent_gate      <= 1'b0;
            o_wheel_detent_gate    <= 1'b0;
            o_car_power_enable     <= 1'b0;
            o_wheel_power_enable   <= 1'b0;
            o_select_fault         <= 2'h0;
            o_car_pos              <= '0;
            o_wheel_pos            <= '0;
            o_wheel_step_up_flag   <= 1'b0;
            o_wheel_step_down_flag <= 1'b0;
            o_car_moved_flag       <= 1'b0;
        end else begin
            sync1                  <= {i_dac_code, i_steer, i_car_sel,
                                       i_wheel_sel, i_car_quad, i_wheel_quad,
                                       i_wheel_step_up_clear,
                                       i_wheel_step_down_clear,
                                       i_car_moved_clear};
            sync2                  <= sync1;
            prime                  <= next_prime;
            car_prev               <= s_car_quad;
            wheel_prev             <= s_wheel_quad;
            o_dac_level            <= next_dac_level;
            o_car_held             <= next_car_held;
            o_wheel_held           <= next_wheel_held;
            o_hammer_energy        <= next_hammer_energy;
            o_car_command          <= next_car_command;
            o_wheel_command        <= next_wheel_command;
            o_car_detent_gate      <= next_car_detent;
            o_wheel_detent_gate    <= next_wheel_detent;
            o_car_power_enable     <= next_car_power;
            o_wheel_power_enable   <= next_wheel_power;
            o_select_fault         <= next_fault;
            o_car_pos              <= s_car_quad;
            o_wheel_pos            <= s_wheel_quad;
            o_wheel_step_up_flag   <= next_step_up;
            o_wheel_step_down_flag <= next_step_down;
            o_car_moved_flag       <= next_car_moved;
        end
    end

endmodule : servo_stage

// ### servo_stage_properties.sv
// Concurrent checks on the servo stage ports
`timescale 1ns/1ps
module servo_stage_properties
    import servo_stage_pkg::*;
(
    // Clock, reset and inputs
    input wire logic               i_mclk,
    input wire logic               i_srst,
    input wire logic [CODE_W-1:0]  i_dac_code,
    input wire sample_steer_type   i_steer,
    input wire servo_select_type   i_car_sel,
    input wire servo_select_type   i_wheel_sel,
    input wire quad_type           i_car_quad,
    input wire quad_type           i_wheel_quad,
    // Watched outputs
    input wire logic [LEVEL_W-1:0] o_dac_level,
    input wire logic [LEVEL_W-1:0] o_car_held,
    input wire logic [CMD_W-1:0]   o_car_command,
    input wire logic               o_car_detent_gate,
    input wire logic               o_wheel_power_enable,
    input wire logic [1:0]         o_select_fault,
    input wire logic               o_wheel_step_up_flag,
    input wire logic               o_wheel_step_down_flag,
    input wire logic               o_car_moved_flag
);
    // --------
    // Guard
    // --------
    // Pipelines carry reset values for a few edges; wait for them to fill
    logic [3:0] age;
    wire        ok = age == 4'hf;
    always_ff @(posedge i_mclk) begin
        age <= i_srst ? 4'h0 : age + {3'h0, !ok};
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    dac_scale_a: assert property (
        ok |-> o_dac_level == LEVEL_W'((PROD_W'(REF_LEVEL)
        * PROD_W'($past(i_dac_code, 3))) >> SCALE_SHIFT)) else $error("scale");
    car_track_a: assert property (
        ok && $past(i_steer.carriage, 3) |-> o_car_held == o_dac_level)
        else $error("carriage sample lost");
    held_keep_a: assert property (
        ok && !$past(i_steer.carriage, 3) |-> $stable(o_car_held))
        else $error("carriage level drifted");
    fwd_pass_a: assert property (
        ok && $past(i_car_sel[3:1], 3) == 3'h4
        |-> o_car_command == {1'b0, $past(o_car_held)}) else $error("fwd");
    detent_gate_a: assert property (
        ok && $past(i_car_sel[3:1], 3) == 3'h1 |-> o_car_detent_gate
        && o_car_command == '0) else $error("detent not gated");
    select_fault_a: assert property (
        ok |-> o_select_fault[1] == ($past(i_car_sel[3:1], 3) inside
        {3'h3, 3'h5, 3'h6, 3'h7})) else $error("conflict missed");
    float_power_a: assert property (
        ok |-> o_wheel_power_enable != $past(i_wheel_sel.drive_disable, 3))
        else $error("power enable wrong");
    step_up_a: assert property (
        ok && i_wheel_quad == PH_0 ##1 i_wheel_quad == PH_1
        |-> ##3 o_wheel_step_up_flag) else $error("step up missed");
    step_down_a: assert property (
        ok && i_wheel_quad == PH_0 ##1 i_wheel_quad == PH_3
        |-> ##3 o_wheel_step_down_flag) else $error("step down missed");
    car_moved_a: assert property (
        ok && ^(i_car_quad ^ $past(i_car_quad))
        |-> ##3 o_car_moved_flag) else $error("carriage motion missed");
endmodule : servo_stage_properties

// ### servo_ctrl_model.sv
// Controller model: codes, strobes, selects and transducer phases
`timescale 1ns/1ps
module servo_ctrl_model
    import servo_stage_pkg::*;
#(
    parameter int SETTLE = 1500, // 6 us of settle at the 4 ns clock
    parameter int STROBE = 500,  // 2 us strobe at the 4 ns clock
    parameter int FLOAT  = 30  // Scaled hold time before float
)
(
    // Clock
    input  wire logic         i_mclk,
    // Toward the servo stage
    output logic [CODE_W-1:0] o_code,
    output sample_steer_type  o_steer,
    output servo_select_type  o_car_sel,
    output servo_select_type  o_wheel_sel,
    output quad_type          o_car_quad,
    output quad_type          o_wheel_quad
);
    localparam logic [1:0] RING [4] = '{PH_0, PH_1, PH_2, PH_3};
    logic [1:0] cph = 2'h0;
    logic [1:0] wph = 2'h0;
    initial begin
        o_code = 8'h00;
        o_steer = '0;
        o_car_sel = '0;
        o_wheel_sel = '0;
    end
    assign o_car_quad = quad_type'(RING[cph]);
    assign o_wheel_quad = quad_type'(RING[wph]);
    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask : tick
    // Shared converter: never more than one strobe up at once
    task automatic put(input logic [7:0] code, input int ch);
        tick();
        o_code = code;
        repeat (SETTLE) tick();
        o_steer = sample_steer_type'(3'h4 >> ch);
        repeat (STROBE) tick();
        o_steer = '0;
    endtask : put
    task automatic sel(input logic car, input logic [3:0] v);
        tick();
        o_car_sel = car ? servo_select_type'(v) : o_car_sel;
        o_wheel_sel = car ? o_wheel_sel : servo_select_type'(v);
    endtask : sel
    task automatic park(input logic car);
        sel(car, 4'h2);
        repeat (FLOAT) tick();
        sel(car, 4'h3);
    endtask : park
    // One phase per call; skipped phases are never produced
    task automatic step(input logic car, input logic up);
        logic [1:0] d;
        d = up ? 2'h1 : 2'h3;
        tick();
        cph = car ? cph + d : cph;
        wph = car ? wph : wph + d;
    endtask : step
endmodule : servo_ctrl_model

// ### servo_stage_bench.sv
// Self-checking bench for the servo stage
`timescale 1ns/1ps
module servo_stage_bench;
    import servo_stage_pkg::*;
    logic               i_mclk = 1'b0;
    logic               i_srst = 1'b1;
    logic               i_wheel_step_up_clear = 1'b0;
    logic               i_wheel_step_down_clear = 1'b0;
    logic               i_car_moved_clear = 1'b0;
    logic [CODE_W-1:0]  i_dac_code;
    sample_steer_type   i_steer;
    servo_select_type   i_car_sel, i_wheel_sel;
    quad_type           i_car_quad, i_wheel_quad, o_car_pos, o_wheel_pos;
    logic [LEVEL_W-1:0] o_dac_level, o_car_held, o_wheel_held;
    logic [LEVEL_W-1:0] o_hammer_energy;
    logic [CMD_W-1:0]   o_car_command, o_wheel_command;
    logic [1:0]         o_select_fault;
    logic               o_car_detent_gate, o_wheel_detent_gate;
    logic               o_car_power_enable, o_wheel_power_enable;
    logic               o_wheel_step_up_flag, o_wheel_step_down_flag;
    logic               o_car_moved_flag;
    int                 miscompares = 0;
    int                 n_compared = 0;
    int                 wheel_count = 0;
    servo_stage dut (.*);
    servo_ctrl_model #(.FLOAT(30)) ctl (.i_mclk(i_mclk), .o_code(i_dac_code),
        .o_steer(i_steer), .o_car_sel(i_car_sel), .o_wheel_sel(i_wheel_sel),
        .o_car_quad(i_car_quad), .o_wheel_quad(i_wheel_quad));
    always #2 i_mclk = ~i_mclk;
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    task automatic check(input logic [CMD_W-1:0] got, exp, input string s);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s: %h not %h", $time, s, got, exp);
        end
    endtask : check
    task automatic settle();
        repeat (5) @(posedge i_mclk);
        #1;
    endtask : settle
    function automatic logic [LEVEL_W-1:0] scale(input logic [7:0] c);
        return LEVEL_W'(({8'h00, REF_LEVEL} * {16'h0000, c}) >> SCALE_SHIFT);
    endfunction : scale
    function automatic logic flag(input int w);
        return w == 0 ? o_wheel_step_up_flag
             : (w == 1 ? o_wheel_step_down_flag : o_car_moved_flag);
    endfunction : flag
    // Waits for a step flag, books the step, then clears the flag
    task automatic take(input int w);
        for (int n = 0; n < 12 && flag(w) !== 1'b1; n++) settle();
        check(flag(w), 1'b1, "step flag");
        if (flag(w) !== 1'b1) results();
        wheel_count += w == 0 ? 1 : (w == 1 ? -1 : 0);
        i_wheel_step_up_clear = w == 0;
        i_wheel_step_down_clear = w == 1;
        i_car_moved_clear = w == 2;
        settle();
        {i_wheel_step_up_clear, i_wheel_step_down_clear} = 2'h0;
        i_car_moved_clear = 1'b0;
        settle();
        check(flag(w), 1'b0, "flag clear");
    endtask : take
    task automatic t_convert();
        logic [7:0] codes [4] = '{8'h00, 8'hff, 8'h80, 8'h01};
        ctl.put(8'h5a, 1);
        foreach (codes[k]) begin
            ctl.put(codes[k], 0);
            settle();
            check(o_dac_level, scale(codes[k]), "level");
            check(o_car_held, scale(codes[k]), "carriage");
            check(o_wheel_held, scale(8'h5a), "wheel");
        end
    endtask : t_convert
    task automatic t_hammer();
        logic [7:0] c;
        for (int k = 0; k < 4; k++) begin
            c = {k[1:0], 6'h2a};
            ctl.put(c, 2);
            settle();
            check(o_hammer_energy, scale(c), "hammer");
            check(o_car_held, scale(8'h01), "carriage kept");
        end
    endtask : t_hammer
    // Six select patterns: forward, reverse, hold and three conflicting pairs
    task automatic t_dir();
        logic [3:0] sels [6] = '{4'h8, 4'h4, 4'h2, 4'hc, 4'ha, 4'h6};
        logic [CMD_W-1:0] h, want;
        logic bad;
        ctl.put(8'hc3, 0);
        h = {1'b0, scale(8'hc3)};
        foreach (sels[k]) begin
            ctl.sel(1'b1, sels[k]);
            settle();
            bad = sels[k][3:1] inside {3'h3, 3'h5, 3'h6};
            want = (bad || sels[k][1]) ? '0 : (sels[k][3] ? h : -h);
            check(o_car_command, want, "command");
            check(o_car_detent_gate, sels[k] == 4'h2, "detent");
            check(o_select_fault, {bad, 1'b0}, "fault");
        end
        ctl.sel(1'b1, 4'h0);
    endtask : t_dir
    task automatic t_steps();
        repeat (5) begin
            ctl.step(1'b0, 1'b1);
            take(0);
        end
        // A new wheel code follows the five counted track crossings
        ctl.put(8'h3c, 1);
        ctl.sel(1'b0, 4'h8);
        settle();
        check(o_wheel_held, scale(8'h3c), "wheel code");
        check(o_wheel_command, {1'b0, scale(8'h3c)}, "wheel fwd");
        // Three down steps so the ring wraps through the first phase
        repeat (3) begin
            ctl.step(1'b0, 1'b0);
            take(1);
        end
        check(17'(wheel_count), 17'h2, "count");
        check(o_wheel_pos, PH_2, "wheel phase");
    endtask : t_steps
    // A nudged carriage leaves float and holds its place again
    task automatic t_float();
        ctl.park(1'b0);
        settle();
        check(o_wheel_power_enable, 1'b0, "wheel float");
        check(o_wheel_detent_gate, 1'b1, "wheel detent");
        ctl.park(1'b1);
        ctl.step(1'b1, 1'b1);
        take(2);
        check(o_car_pos, PH_1, "carriage phase");
        ctl.sel(1'b1, 4'h2);
        settle();
        check(o_car_power_enable, 1'b1, "carriage powered");
        check(o_car_detent_gate, 1'b1, "carriage held");
    endtask : t_float
    initial begin
        repeat (16) @(posedge i_mclk);
        #1;
        check(o_car_power_enable, 1'b0, "reset power");
        check(o_car_command, '0, "reset command");
        i_srst = 1'b0;
        settle();
        check(o_wheel_power_enable, 1'b1, "powered");
        t_convert();
        t_hammer();
        t_dir();
        t_steps();
        t_float();
        results();
    end
    initial begin
        repeat (40000) @(posedge i_mclk);
        miscompares++;
        results();
    end
endmodule : servo_stage_bench

bind servo_stage servo_stage_properties chk (.*);
